// File: bis_pkg.sv
// constants, state codes and timing for the burner ignition sequencer
// assumes a single 10 MHz clock and seconds derived from it by a divider
package bis_pkg;
    // ==========================================================
    // timing
    localparam int unsigned CLK_PERIOD_NS = 100;
    localparam int unsigned SECOND_NS = 1000000000;
    localparam int unsigned TICK_CYCLES = SECOND_NS / CLK_PERIOD_NS;
    localparam int unsigned CNT_W = 24;
    localparam int unsigned SEC_W = 8;
    localparam logic [SEC_W-1:0] SELF_CHECK_S = 8'h01;
    localparam logic [SEC_W-1:0] PREPURGE_S = 8'h0F;
    localparam logic [SEC_W-1:0] WARMUP_S = 8'h14;
    localparam logic [SEC_W-1:0] TRIAL_S = 8'h06;
    localparam logic [SEC_W-1:0] IGN_OFF_S = 8'h02;
    localparam logic [SEC_W-1:0] PROVE_FROM_S = 8'h04;
    localparam logic [SEC_W-1:0] POSTPURGE_S = 8'h1E;
    localparam logic [SEC_W-1:0] SEC_MAX = 8'hFF;
    // ==========================================================
    // sequencer states
    typedef enum logic [9:0] {
        S_IDLE = 10'h001,
        S_CHECK = 10'h002,
        S_WAIT_AIR = 10'h004,
        S_PREPURGE = 10'h008,
        S_WARMUP = 10'h010,
        S_TRIAL = 10'h020,
        S_RUN = 10'h040,
        S_POSTPURGE = 10'h080,
        S_HOLD = 10'h100,
        S_LOCKOUT = 10'h200
    } bis_state_t;
endpackage

// File: bis_tmr_if.sv
// phase timer link between sequencer and seconds timer
// assumes both ends share sys_clk
`timescale 1ns/1ps
interface bis_tmr_if;
    logic restart;
    logic [bis_pkg::SEC_W-1:0] secs;
    modport seq (output restart, input secs);
    modport timer (input restart, output secs);
endinterface

// File: bis_timer.sv
// seconds timer: divides sys_clk to one-second ticks and counts them
// assumes restart is a one-cycle pulse on every phase change
`timescale 1ns/1ps
module bis_timer #(
    parameter int unsigned TICK_CYCLES = bis_pkg::TICK_CYCLES
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // sequencer side
    bis_tmr_if.timer tmr
);
    logic [bis_pkg::CNT_W-1:0] cnt_q;
    logic [bis_pkg::SEC_W-1:0] secs_q;
    logic tick;

    // ==========================================================
    // divider, cleared on restart so every phase starts on a whole second
    assign tick = (cnt_q == bis_pkg::CNT_W'(TICK_CYCLES - 1));

    always_ff @(posedge sys_clk) begin
        if (!resetn || tmr.restart || tick) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    // ==========================================================
    // seconds count saturates so a long hold never wraps
    always_ff @(posedge sys_clk) begin
        if (!resetn || tmr.restart) begin
            secs_q <= '0;
        end else if (tick && secs_q != bis_pkg::SEC_MAX) begin
            secs_q <= secs_q + 1'b1;
        end
    end

    assign tmr.secs = secs_q;
endmodule

// File: bis_burner_controller.sv
// burner ignition sequencer: phases, load drives and indicator lamps
// assumes inputs synchronous to sys_clk; limit setpoint kept in range outside
`timescale 1ns/1ps
module bis_burner_controller #(
    parameter int unsigned TICK_CYCLES = bis_pkg::TICK_CYCLES
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // sensing
    input wire logic heat_demand,
    input wire logic air_proven,
    input wire logic flame_sensed,
    input wire logic limit_ok,
    input wire logic safety_ok,
    // loads
    output logic circulator_on,
    output logic inducer_on,
    output logic igniter_on,
    output logic gas_valve_on,
    // lamps
    output logic lamp_power,
    output logic lamp_air,
    output logic lamp_igniter,
    output logic lamp_valve,
    output logic lamp_flame,
    output logic lockout
);
    bis_pkg::bis_state_t st_q, st_d;
    logic burner_ok;
    logic [bis_pkg::SEC_W-1:0] secs;

    bis_tmr_if tmr ();

    bis_timer #(.TICK_CYCLES(TICK_CYCLES)) u_timer (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .tmr(tmr)
    );

    assign secs = tmr.secs;
    // limit and added safety controls both pull the burner down
    assign burner_ok = limit_ok && safety_ok;
    assign tmr.restart = (st_d != st_q);

    // ==========================================================
    // shared phase decodes, so a drive and its lamp cannot drift apart
    // the igniter is cut by the trial's own seconds count, not a second timer
    function automatic logic igniter_phase(
        input bis_pkg::bis_state_t st,
        input logic [bis_pkg::SEC_W-1:0] s
    );
        return (st == bis_pkg::S_WARMUP) || (st == bis_pkg::S_TRIAL && s < bis_pkg::IGN_OFF_S);
    endfunction

    function automatic logic valve_phase(input bis_pkg::bis_state_t st);
        return (st == bis_pkg::S_TRIAL) || (st == bis_pkg::S_RUN);
    endfunction

    // ==========================================================
    // phase sequencing
    always_comb begin
        st_d = st_q;
        unique case (st_q)
            bis_pkg::S_IDLE: begin
                if (heat_demand) begin
                    st_d = bis_pkg::S_CHECK;
                end
            end
            bis_pkg::S_CHECK: begin
                if (!heat_demand) begin
                    st_d = bis_pkg::S_IDLE;
                end else if (secs >= bis_pkg::SELF_CHECK_S) begin
                    st_d = burner_ok ? bis_pkg::S_WAIT_AIR : bis_pkg::S_HOLD;
                end
            end
            bis_pkg::S_WAIT_AIR: begin
                if (!heat_demand) begin
                    st_d = bis_pkg::S_POSTPURGE;
                end else if (!burner_ok) begin
                    st_d = bis_pkg::S_HOLD;
                end else if (air_proven) begin
                    st_d = bis_pkg::S_PREPURGE;
                end
            end
            bis_pkg::S_PREPURGE: begin
                if (!heat_demand) begin
                    st_d = bis_pkg::S_POSTPURGE;
                end else if (!burner_ok) begin
                    st_d = bis_pkg::S_HOLD;
                end else if (secs >= bis_pkg::PREPURGE_S) begin
                    st_d = bis_pkg::S_WARMUP;
                end
            end
            bis_pkg::S_WARMUP: begin
                if (!heat_demand) begin
                    st_d = bis_pkg::S_POSTPURGE;
                end else if (!burner_ok) begin
                    st_d = bis_pkg::S_HOLD;
                end else if (secs >= bis_pkg::WARMUP_S) begin
                    st_d = bis_pkg::S_TRIAL;
                end
            end
            bis_pkg::S_TRIAL: begin
                if (!heat_demand) begin
                    st_d = bis_pkg::S_POSTPURGE;
                end else if (!burner_ok) begin
                    st_d = bis_pkg::S_HOLD;
                end else if (flame_sensed && secs >= bis_pkg::PROVE_FROM_S) begin
                    st_d = bis_pkg::S_RUN;
                end else if (secs >= bis_pkg::TRIAL_S) begin
                    st_d = bis_pkg::S_LOCKOUT;
                end
            end
            bis_pkg::S_RUN: begin
                if (!heat_demand) begin
                    st_d = bis_pkg::S_POSTPURGE;
                end else if (!burner_ok) begin
                    st_d = bis_pkg::S_HOLD;
                end else if (!flame_sensed) begin
                    st_d = bis_pkg::S_LOCKOUT;
                end
            end
            bis_pkg::S_POSTPURGE: begin
                // a new demand waits until the purge has finished
                if (secs >= bis_pkg::POSTPURGE_S) begin
                    st_d = bis_pkg::S_IDLE;
                end
            end
            bis_pkg::S_HOLD: begin
                if (!heat_demand) begin
                    st_d = bis_pkg::S_IDLE;
                end else if (burner_ok) begin
                    st_d = bis_pkg::S_WAIT_AIR;
                end
            end
            bis_pkg::S_LOCKOUT: begin
                // only a reset leaves; no automatic retry on gas
                st_d = bis_pkg::S_LOCKOUT;
            end
            default: begin
                st_d = bis_pkg::S_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            st_q <= bis_pkg::S_IDLE;
        end else begin
            st_q <= st_d;
        end
    end

    // ==========================================================
    // load drives, registered from the current phase
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            circulator_on <= 1'b0;
            inducer_on <= 1'b0;
            igniter_on <= 1'b0;
            gas_valve_on <= 1'b0;
        end else begin
            circulator_on <= st_q inside {bis_pkg::S_CHECK, bis_pkg::S_WAIT_AIR,
                bis_pkg::S_PREPURGE, bis_pkg::S_WARMUP, bis_pkg::S_TRIAL,
                bis_pkg::S_RUN, bis_pkg::S_HOLD};
            inducer_on <= st_q inside {bis_pkg::S_WAIT_AIR, bis_pkg::S_PREPURGE,
                bis_pkg::S_WARMUP, bis_pkg::S_TRIAL, bis_pkg::S_RUN,
                bis_pkg::S_POSTPURGE};
            igniter_on <= igniter_phase(st_q, secs);
            gas_valve_on <= valve_phase(st_q);
        end
    end

    // ==========================================================
    // indicator lamps
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            lamp_power <= 1'b1;
            lamp_air <= 1'b0;
            lamp_igniter <= 1'b0;
            lamp_valve <= 1'b0;
            lamp_flame <= 1'b0;
            lockout <= 1'b0;
        end else begin
            lamp_power <= 1'b1;
            lamp_air <= (st_q == bis_pkg::S_PREPURGE) ||
                (st_q == bis_pkg::S_POSTPURGE);
            lamp_igniter <= igniter_phase(st_q, secs);
            lamp_valve <= valve_phase(st_q);
            lamp_flame <= (st_q == bis_pkg::S_RUN);
            lockout <= (st_q == bis_pkg::S_LOCKOUT);
        end
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    // outputs lag their state by one edge, hence the |=> forms

    a_idle_lamps_dark: assert property (
        (st_q == bis_pkg::S_IDLE) |=> lamp_power && !lamp_air && !lamp_igniter
            && !lamp_valve && !lamp_flame)
        else $error("idle lamps wrong");
    a_demand_circ_on: assert property (
        (st_q == bis_pkg::S_IDLE && heat_demand) |=> ##1 circulator_on)
        else $error("circulator not on after demand");
    a_check_then_inducer: assert property (
        $rose(inducer_on) |-> $past(st_q == bis_pkg::S_WAIT_AIR) &&
            ($past(st_q == bis_pkg::S_CHECK, 2) || $past(st_q == bis_pkg::S_HOLD, 2)))
        else $error("inducer before self-check");
    a_prepurge_air_lamp: assert property (
        (st_q == bis_pkg::S_PREPURGE) |=> lamp_air && inducer_on)
        else $error("pre-purge lamp or inducer off");
    a_prepurge_length: assert property (
        (st_q == bis_pkg::S_WARMUP && $past(st_q == bis_pkg::S_PREPURGE))
            |-> $past(secs) == bis_pkg::PREPURGE_S || !$past(heat_demand))
        else $error("pre-purge length wrong");
    a_warmup_igniter: assert property (
        (st_q == bis_pkg::S_WARMUP) |=> igniter_on && lamp_igniter && !lamp_air
            && !gas_valve_on)
        else $error("warm-up outputs wrong");
    a_trial_valve_on: assert property (
        $rose(st_q == bis_pkg::S_TRIAL) |=> gas_valve_on && lamp_valve && igniter_on)
        else $error("valve not opened for trial");
    a_igniter_cut: assert property (
        (st_q == bis_pkg::S_TRIAL && secs >= bis_pkg::IGN_OFF_S)
            |=> !igniter_on && !lamp_igniter)
        else $error("igniter still on late in trial");
    a_no_early_run: assert property (
        $rose(st_q == bis_pkg::S_RUN) |-> $past(secs) >= bis_pkg::PROVE_FROM_S
            && $past(flame_sensed))
        else $error("run entered without proving");
    a_post_loads: assert property (
        (st_q == bis_pkg::S_POSTPURGE) |=> !gas_valve_on && !circulator_on
            && inducer_on && lamp_air && !lamp_valve)
        else $error("post-purge outputs wrong");
    a_post_end_idle: assert property (
        (st_q == bis_pkg::S_POSTPURGE && secs >= bis_pkg::POSTPURGE_S)
            |=> st_q == bis_pkg::S_IDLE ##1 !inducer_on && !lamp_air)
        else $error("post-purge did not end");
    a_trial_fail_close: assert property (
        (st_q == bis_pkg::S_TRIAL && secs >= bis_pkg::TRIAL_S && !flame_sensed
            && heat_demand && burner_ok) |=> ##1 !gas_valve_on && !lamp_valve)
        else $error("valve open after failed trial");
    a_trip_burner_off: assert property (
        (st_q == bis_pkg::S_RUN && heat_demand && !burner_ok)
            |=> ##1 !gas_valve_on && circulator_on)
        else $error("trip did not stop burner");
    a_lockout_held: assert property (
        (st_q == bis_pkg::S_LOCKOUT) |=> st_q == bis_pkg::S_LOCKOUT ##1
            !gas_valve_on && !igniter_on)
        else $error("lockout released");

    // phase lengths, each counted in whole seconds from phase entry
    a_check_length: assert property (
        ($rose(st_q == bis_pkg::S_WAIT_AIR) && $past(st_q == bis_pkg::S_CHECK))
            |-> $past(secs) == bis_pkg::SELF_CHECK_S)
        else $error("self-check length wrong");
    a_warmup_length: assert property (
        (st_q == bis_pkg::S_TRIAL && $past(st_q == bis_pkg::S_WARMUP))
            |-> $past(secs) == bis_pkg::WARMUP_S)
        else $error("warm-up length wrong");
    a_trial_length: assert property (
        ($rose(st_q == bis_pkg::S_LOCKOUT) && $past(st_q == bis_pkg::S_TRIAL))
            |-> $past(secs) == bis_pkg::TRIAL_S)
        else $error("trial length wrong");
    // a short reset can also drop the purge state, so reset edges are left out
    a_post_length: assert property (
        (st_q == bis_pkg::S_IDLE && $past(st_q == bis_pkg::S_POSTPURGE) && $past(resetn))
            |-> $past(secs) == bis_pkg::POSTPURGE_S)
        else $error("post-purge length wrong");

    // load patterns of the check, run, hold and lockout phases, and the hold relight
    a_check_quiet: assert property (
        (st_q == bis_pkg::S_CHECK) |=> circulator_on && !inducer_on && !gas_valve_on)
        else $error("self-check loads wrong");
    a_run_loads: assert property (
        (st_q == bis_pkg::S_RUN) |=> gas_valve_on && lamp_valve && lamp_flame
            && !igniter_on && !lamp_igniter)
        else $error("run outputs wrong");
    a_hold_loads: assert property (
        (st_q == bis_pkg::S_HOLD) |=> circulator_on && !inducer_on && !igniter_on
            && !gas_valve_on)
        else $error("hold outputs wrong");
    a_hold_relight: assert property (
        (st_q == bis_pkg::S_HOLD && heat_demand && burner_ok) |=> st_q == bis_pkg::S_WAIT_AIR)
        else $error("no relight after trip cleared");
    a_lockout_loads: assert property (
        (st_q == bis_pkg::S_LOCKOUT) |=> lockout && !circulator_on && !inducer_on
            && !lamp_valve)
        else $error("lockout outputs wrong");

    // main scenarios
    c_self_check: cover property ($rose(st_q == bis_pkg::S_WAIT_AIR));
    c_full_run: cover property ($rose(st_q == bis_pkg::S_RUN));
    c_trial_fail: cover property ($rose(st_q == bis_pkg::S_LOCKOUT));
    c_trip_relight: cover property (st_q == bis_pkg::S_HOLD ##1 st_q == bis_pkg::S_WAIT_AIR);
    c_post_done: cover property (st_q == bis_pkg::S_POSTPURGE ##1 st_q == bis_pkg::S_IDLE);
endmodule

// File: bis_far_side.sv
// behavioural model of the loads and switches around the burner controller
// assumes the bench steers air, flame and water temperature per scenario
`timescale 1ns/1ps
module bis_far_side #(
    parameter logic [7:0] LIMIT_F = 8'h96
) (
    // clock
    input wire logic sys_clk,
    // loads from the controller
    input wire logic inducer_on,
    input wire logic gas_valve_on,
    // scenario controls
    input wire logic air_en,
    input wire logic flame_en,
    input wire logic [7:0] water_temp,
    // switches and sensors
    output logic air_proven,
    output logic flame_sensed,
    output logic limit_ok
);
    // ==========================================================
    // switches
    logic [2:0] spin_q = 3'h0;
    // air switch closes only once the inducer has spun up, never ahead of it
    always @(posedge sys_clk) spin_q <= {spin_q[1:0], inducer_on};
    assign air_proven = air_en & (&spin_q);
    // flame exists only while gas flows
    assign flame_sensed = flame_en & gas_valve_on;
    // setpoint held inside 100..200 F
    assign limit_ok = (water_temp < LIMIT_F);
endmodule

// File: burner_ignition_sequencer_bench.sv
// self-checking bench for the burner controller
// assumes a short seconds tick of T cycles; far side is a behavioural model
`timescale 1ns/1ps
module burner_ignition_sequencer_bench;
    // ==========================================================
    // signals
    localparam int T = 10;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic heat_demand = 1'b0;
    logic safety_ok = 1'b1;
    logic air_en = 1'b1;
    logic flame_en = 1'b1;
    logic [7:0] water_temp = 8'h78;
    logic air_proven;
    logic flame_sensed;
    logic limit_ok;
    wire [9:0] outs;
    int num_errors = 0;
    int checks = 0;
    always #50 sys_clk = ~sys_clk;
    bis_burner_controller #(.TICK_CYCLES(T)) dut (.sys_clk(sys_clk), .resetn(resetn),
        .heat_demand(heat_demand), .air_proven(air_proven), .flame_sensed(flame_sensed),
        .limit_ok(limit_ok), .safety_ok(safety_ok), .circulator_on(outs[0]),
        .inducer_on(outs[1]), .igniter_on(outs[2]), .gas_valve_on(outs[3]),
        .lamp_air(outs[4]), .lamp_igniter(outs[5]), .lamp_valve(outs[6]),
        .lamp_flame(outs[7]), .lockout(outs[8]), .lamp_power(outs[9]));
    bis_far_side far (.sys_clk(sys_clk), .inducer_on(outs[1]), .gas_valve_on(outs[3]),
        .air_en(air_en), .flame_en(flame_en), .water_temp(water_temp),
        .air_proven(air_proven), .flame_sensed(flame_sensed), .limit_ok(limit_ok));
    // ==========================================================
    // helpers
    task automatic conclude();
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input string what, input logic [9:0] exp, input logic [9:0] got);
        checks++;
        if (exp !== got) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic rng(input string what, input int lo, input int hi, input int got);
        checks++;
        if (got < lo || got > hi) begin
            num_errors++;
            $display("mismatch %s expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge sys_clk);
        #1;
    endtask
    // bounded wait; a long limit covers a whole start-up sequence
    task automatic wait_lvl(input int i, input logic v, output int n);
        n = 0;
        while (outs[i] !== v) begin
            if (n > 60 * T) begin
                num_errors++;
                $display("mismatch wait output %0d expected %b seen %b", i, v, outs[i]);
                conclude();
            end
            @(posedge sys_clk);
            #1;
            n++;
        end
    endtask
    task automatic demand(input logic v);
        @(posedge sys_clk) heat_demand <= v;
        #1;
    endtask
    // ==========================================================
    // scenarios
    task automatic t_idle();
        chk("idle lamps", 10'h200, outs);
    endtask
    task automatic t_normal();
        int n;
        int tot;
        demand(1'b1);
        wait_lvl(0, 1'b1, n);
        tot = n;
        chk("inducer during self check", 10'h201, outs);
        wait_lvl(1, 1'b1, n);
        tot += n;
        rng("self check", T - 1, 2 * T, n);
        wait_lvl(4, 1'b1, n);
        tot += n;
        chk("pre-purge outputs", 10'h213, outs);
        wait_lvl(2, 1'b1, n);
        tot += n;
        rng("pre-purge", 15 * T, 15 * T + 1, n);
        chk("warm-up outputs", 10'h227, outs);
        wait_lvl(3, 1'b1, n);
        tot += n;
        rng("warm-up", 20 * T, 20 * T + 1, n);
        chk("trial outputs", 10'h26F, outs);
        rng("demand to valve", 35 * T, 42 * T, tot);
        wait_lvl(2, 1'b0, n);
        rng("igniter on in trial", 2 * T, 2 * T + 1, n);
        chk("igniter lamp", {6'h00, 4'h2}, {6'h00, outs[5:2]});
        wait_lvl(7, 1'b1, n);
        rng("flame proving", 1, 2 * T + 2, n);
        cyc(10 * T);
        chk("run outputs", 10'h2CB, outs);
        demand(1'b0);
        wait_lvl(3, 1'b0, n);
        chk("post-purge outputs", 10'h212, outs);
        wait_lvl(1, 1'b0, n);
        rng("post-purge", 30 * T, 30 * T + 1, n);
        chk("back to standby", 10'h200, outs);
    endtask
    // sel 0 trips the high limit, sel 1 opens an added safety input
    task automatic t_trip(input bit sel);
        int n;
        demand(1'b1);
        wait_lvl(7, 1'b1, n);
        @(posedge sys_clk);
        if (sel)
            safety_ok <= 1'b0;
        else
            water_temp <= 8'hB4;
        #1;
        wait_lvl(3, 1'b0, n);
        rng("trip reaction", 1, 3, n);
        cyc(5 * T);
        chk("held loads", 10'h004, {7'h00, outs[0], outs[3:2]});
        @(posedge sys_clk);
        safety_ok <= 1'b1;
        water_temp <= 8'h78;
        #1;
        wait_lvl(3, 1'b1, n);
        rng("relight delay", 35 * T, 35 * T + 12, n);
        demand(1'b0);
        wait_lvl(1, 1'b0, n);
    endtask
    task automatic t_noflame();
        int n;
        @(posedge sys_clk) flame_en <= 1'b0;
        demand(1'b1);
        wait_lvl(3, 1'b1, n);
        wait_lvl(3, 1'b0, n);
        rng("trial without flame", 6 * T, 6 * T + 1, n);
        chk("valve lamp", 10'h000, {9'h000, outs[6]});
        chk("lockout flag", 10'h001, {9'h000, outs[8]});
        // demand stays on: an automatic retry would reopen the valve here
        cyc(45 * T);
        chk("no retry", 10'h000, {8'h00, outs[3:2]});
        @(posedge sys_clk) resetn <= 1'b0;
        heat_demand <= 1'b0;
        flame_en <= 1'b1;
        cyc(2);
        @(posedge sys_clk) resetn <= 1'b1;
        cyc(2);
        chk("restart clears", 10'h200, outs);
    endtask
    // ==========================================================
    // main sequence
    initial begin
        repeat (16) @(posedge sys_clk);
        resetn <= 1'b1;
        cyc(2);
        t_idle();
        t_normal();
        t_trip(1'b0);
        t_trip(1'b1);
        t_noflame();
        conclude();
    end
endmodule
